// [design/csb_defs.svh]
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH
// register byte offsets
`define CSB_REG_BUSCTL   8'h00
`define CSB_REG_COUNT    8'h04
`define CSB_REG_COMPARE  8'h08
`define CSB_REG_PORTSZ   8'h0c
`define CSB_REG_CACHE    8'h10
`define CSB_REG_STATUS   8'h14
// bus control fields
`define CSB_BC_MASK_RD   0
`define CSB_BC_TC_HOLD   1
`define CSB_BUSCTL_RST   2'h0
`define CSB_PORTSZ_RST   8'h00
`define CSB_CACHE_RST    2'h0
// port size codes, two bits per region
`define CSB_PS_32        2'h0
`define CSB_PS_16        2'h1
`define CSB_PS_8         2'h2
// timer
`define CSB_TMR_W        24
// terminal pulse, in tenths of a processor cycle
`define CSB_TC_PROC_X10  15
`define CSB_CLK_PER_PROC 2
`define CSB_TC_CLKS ((`CSB_TC_PROC_X10 * `CSB_CLK_PER_PROC) / 10)
`endif

// [design/csb_pkg.sv]
package csb_pkg;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [31:0] vaddr;
		logic [2:0]  nbytes;
	} csb_xfer_t;

	typedef struct packed {
		logic       addr_show_force_miss;
		logic       high_byte_first_order;
		logic [1:0] spare_high_option;
	} csb_strap_t;

	typedef struct packed {
		logic block_size;
		logic refill_alg;
	} csb_cache_t;

	typedef enum logic [1:0] {
		CSB_IDLE = 2'b00,
		CSB_RD   = 2'b01,
		CSB_WR   = 2'b10
	} csb_state_t;
endpackage : csb_pkg

// [design/csb_sideband.sv]
// Functional notes
// - drive two active-low lane strobes for 16-bit port accesses
// - upper strobe marks most significant byte, lane set by byte order
// - lower strobe marks least significant byte, lane set by byte order
// - bus control mask bit keeps both lane strobes high during reads
// - lane strobe pins are inputs during reset, sampling spare options
// - final-datum low after next-to-last ack, or from the start if one datum, released with strobe
// - terminal output low 1.5 cycles or until timer rewritten, by mode
// - 24-bit count and compare timer
// - bus fault sampled only while a read or write is in progress
// - bus fault on a read raises bus error exception
// - synchronized interrupts pass a two-flop synchroniser
// - direct interrupts are seen one cycle sooner than synchronized
// - reset samples direct irq 3 and synced irq 0 as options
// - processor timing is half the double-rate input clock
// - configuration captured in the last cycle reset is held
// - float input releases every output, clock and grant included
// - software sets 8, 16 or 32-bit port width per region
// - cache configuration selects block size and refill algorithm
// - reserved address ranges map like their segment, never trap
// - configuration pins act as inputs only while reset is held
`timescale 1ns/10ps
`include "csb_defs.svh"
module csb_sideband (
	// clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	// register port
	input  wire logic [7:0]        i_reg_addr,
	input  wire logic [31:0]       i_reg_wdata,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	output logic      [31:0]       o_reg_rdata,
	// transfer requests from the core
	input  wire logic              i_xfer_valid,
	input  wire csb_pkg::csb_xfer_t i_xfer,
	output logic                   o_xfer_busy,
	output logic                   o_bus_err_exc,
	output logic      [31:0]       o_paddr,
	// bus pins
	input  wire logic              i_read_data_strobe_n,
	input  wire logic              i_ack_n,
	input  wire logic              i_bus_fault_in,
	input  wire logic              i_bus_req,
	input  wire logic              i_float_all_outputs,
	output logic                   o_rd_n,
	output logic                   o_wr_n,
	output logic                   o_ctl_oe,
	output logic                   o_last_n,
	output logic      [1:0]        o_half_port_lane_strobe_n,
	output logic                   o_lane_oe,
	input  wire logic [1:0]        i_half_port_lane_strobe_n,
	output logic                   o_timer_terminal_n,
	output logic                   o_system_clock_out,
	output logic                   o_bus_grant_out,
	output logic                   o_fixed_oe,
	// interrupts
	input  wire logic [2:0]        i_synced_irq_n,
	input  wire logic [2:0]        i_direct_irq_n,
	output logic      [5:0]        o_irq_pending,
	// configuration
	output csb_pkg::csb_strap_t    o_strap,
	output csb_pkg::csb_cache_t    o_cache_cfg
);
	csb_pkg::csb_state_t state_ff;
	logic                system_clock_out_ff;
	logic                proc_en;
	logic [1:0]          busctl_ff;
	logic [7:0]          portsz_ff;
	logic [`CSB_TMR_W-1:0] count_ff;
	logic [`CSB_TMR_W-1:0] cmp_ff;
	logic [1:0]          tc_cnt_ff;
	logic [2:0]          left_ff;
	logic [2:0]          bytes_ff;
	logic [1:0]          off_ff;
	logic [1:0]          width_ff;
	logic                grant_ff;
	logic [2:0]          sync1_ff;
	logic [2:0]          sync2_ff;
	logic [2:0]          direct_ff;
	logic                count_wr;
	logic                tc_hit;
	logic                ack;
	logic [2:0]          step;
	logic [1:0]          nxt_width;
	logic [31:0]         nxt_paddr;
	logic [31:0]         nxt_rdata;

	// ceil(nbytes / port width), aligned transfers assumed
	function automatic logic [2:0] csb_datums(input logic [2:0] nb,
		input logic [1:0] ps);
		case (ps)
			`CSB_PS_16: csb_datums = 3'((4'(nb) + 4'h1) >> 1);
			`CSB_PS_8:  csb_datums = nb;
			default:    csb_datums = 3'h1;
		endcase
	endfunction : csb_datums

	function automatic logic [2:0] csb_step(input logic [1:0] ps);
		case (ps)
			`CSB_PS_16: csb_step = 3'h2;
			`CSB_PS_8:  csb_step = 3'h1;
			default:    csb_step = 3'h4;
		endcase
	endfunction : csb_step

	// active-low {upper, lower} lanes of a 16-bit port
	function automatic logic [1:0] csb_lanes(input logic [1:0] ps,
		input logic [1:0] off, input logic [2:0] nb,
		input logic big, input logic masked);
		logic upper;
		upper = 1'b0;
		if (ps != `CSB_PS_16 || masked) begin
			csb_lanes = 2'h3;
		end else if (nb >= 3'h2 && !off[0]) begin
			csb_lanes = 2'h0;
		end else begin
			upper = big ? !off[0] : off[0];
			csb_lanes = upper ? 2'h1 : 2'h2;
		end
	endfunction : csb_lanes

	// kseg0 and kseg1 fold onto low memory, all else passes untouched
	always_comb begin
		nxt_paddr = i_xfer.vaddr;
		if (i_xfer.vaddr[31:30] == 2'h2) begin
			nxt_paddr = {3'h0, i_xfer.vaddr[28:0]};
		end
		nxt_width = portsz_ff[2*nxt_paddr[29:28] +: 2];
	end

	assign proc_en  = !system_clock_out_ff;
	assign count_wr = i_reg_wr && i_reg_addr == `CSB_REG_COUNT;
	assign tc_hit   = proc_en && count_ff == cmp_ff;
	assign step     = csb_step(width_ff);
	assign ack      = state_ff == csb_pkg::CSB_RD ? !i_read_data_strobe_n
		: !i_ack_n;

	// processor clock is the double-rate input divided by two
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			system_clock_out_ff <= 1'b0;
		end else begin
			system_clock_out_ff <= !system_clock_out_ff;
		end
	end
	assign o_system_clock_out = system_clock_out_ff;

	// strap capture; the last sample taken under reset is kept
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_strap.addr_show_force_miss  <= !i_direct_irq_n[0];
			o_strap.high_byte_first_order <= !i_synced_irq_n[0];
			o_strap.spare_high_option <= i_half_port_lane_strobe_n;
		end
	end

	// output enables; lane pins are inputs while reset is held
	always_ff @(posedge i_clk_sys) begin
		o_lane_oe  <= !i_float_all_outputs && !i_rst;
		o_fixed_oe <= !i_float_all_outputs;
		o_ctl_oe   <= !i_float_all_outputs && !grant_ff;
	end

	// software registers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			busctl_ff   <= `CSB_BUSCTL_RST;
			portsz_ff   <= `CSB_PORTSZ_RST;
			o_cache_cfg <= `CSB_CACHE_RST;
			cmp_ff      <= '0;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`CSB_REG_BUSCTL:  busctl_ff   <= i_reg_wdata[1:0];
				`CSB_REG_PORTSZ:  portsz_ff   <= i_reg_wdata[7:0];
				`CSB_REG_CACHE:   o_cache_cfg <= i_reg_wdata[1:0];
				`CSB_REG_COMPARE: cmp_ff <= i_reg_wdata[`CSB_TMR_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		case (i_reg_addr)
			`CSB_REG_BUSCTL:  nxt_rdata = {30'h0, busctl_ff};
			`CSB_REG_COUNT:   nxt_rdata = {8'h0, count_ff};
			`CSB_REG_COMPARE: nxt_rdata = {8'h0, cmp_ff};
			`CSB_REG_PORTSZ:  nxt_rdata = {24'h0, portsz_ff};
			`CSB_REG_CACHE:   nxt_rdata = {30'h0, o_cache_cfg};
			`CSB_REG_STATUS:  nxt_rdata = {26'h0, !o_timer_terminal_n,
				o_xfer_busy, o_strap};
			default:          nxt_rdata = 32'h0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_reg_rdata <= 32'h0;
		end else begin
			o_reg_rdata <= i_reg_rd ? nxt_rdata : 32'h0;
		end
	end

	// timer; a software write to the count restarts it
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			count_ff <= '0;
		end else if (count_wr) begin
			count_ff <= i_reg_wdata[`CSB_TMR_W-1:0];
		end else if (tc_hit) begin
			count_ff <= '0;
		end else if (proc_en) begin
			count_ff <= count_ff + 1'b1;
		end
	end

	// terminal pin: fixed 1.5-cycle pulse or held until rewrite
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_timer_terminal_n <= 1'b1;
			tc_cnt_ff          <= 2'h0;
		end else if (tc_hit && !count_wr) begin
			o_timer_terminal_n <= 1'b0;
			tc_cnt_ff <= 2'(`CSB_TC_CLKS - 1);
		end else if (busctl_ff[`CSB_BC_TC_HOLD]) begin
			if (count_wr) begin
				o_timer_terminal_n <= 1'b1;
			end
		end else if (tc_cnt_ff != 2'h0) begin
			tc_cnt_ff <= tc_cnt_ff - 2'h1;
		end else begin
			o_timer_terminal_n <= 1'b1;
		end
	end

	// bus grant to an external master, only between transfers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			grant_ff <= 1'b0;
		end else if (proc_en) begin
			grant_ff <= i_bus_req && state_ff == csb_pkg::CSB_IDLE
				&& !(i_xfer_valid && !grant_ff);
		end
	end
	assign o_bus_grant_out = grant_ff;

	// transfer sequencer, steps on processor edges only
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_ff    <= csb_pkg::CSB_IDLE;
			o_rd_n      <= 1'b1;
			o_wr_n      <= 1'b1;
			o_last_n    <= 1'b1;
			o_xfer_busy <= 1'b0;
			o_half_port_lane_strobe_n <= 2'h3;
			left_ff  <= 3'h0;
			bytes_ff <= 3'h0;
			off_ff   <= 2'h0;
			width_ff <= `CSB_PS_32;
			o_paddr  <= 32'h0;
		end else if (proc_en) begin
			case (state_ff)
				csb_pkg::CSB_IDLE: begin
					if (i_xfer_valid && !grant_ff
						&& (i_xfer.rd || i_xfer.wr)) begin
						state_ff <= i_xfer.rd ? csb_pkg::CSB_RD
							: csb_pkg::CSB_WR;
						o_rd_n      <= !i_xfer.rd;
						o_wr_n      <= i_xfer.rd;
						o_xfer_busy <= 1'b1;
						o_paddr     <= nxt_paddr;
						width_ff    <= nxt_width;
						off_ff      <= nxt_paddr[1:0];
						bytes_ff    <= i_xfer.nbytes;
						left_ff <= csb_datums(i_xfer.nbytes, nxt_width);
						o_last_n <= csb_datums(i_xfer.nbytes,
							nxt_width) != 3'h1;
						o_half_port_lane_strobe_n <= csb_lanes(nxt_width,
							nxt_paddr[1:0], i_xfer.nbytes,
							o_strap.high_byte_first_order,
							i_xfer.rd && busctl_ff[`CSB_BC_MASK_RD]);
					end
				end
				csb_pkg::CSB_RD, csb_pkg::CSB_WR: begin
					if (i_bus_fault_in || (ack && left_ff == 3'h1)) begin
						state_ff    <= csb_pkg::CSB_IDLE;
						o_rd_n      <= 1'b1;
						o_wr_n      <= 1'b1;
						o_last_n    <= 1'b1;
						o_xfer_busy <= 1'b0;
						o_half_port_lane_strobe_n <= 2'h3;
					end else if (ack) begin
						left_ff  <= left_ff - 3'h1;
						off_ff   <= off_ff + step[1:0];
						bytes_ff <= bytes_ff - step;
						if (left_ff == 3'h2) begin
							o_last_n <= 1'b0;
						end
						o_half_port_lane_strobe_n <= csb_lanes(width_ff,
							off_ff + 2'h2, bytes_ff - 3'h2,
							o_strap.high_byte_first_order,
							state_ff == csb_pkg::CSB_RD
							&& busctl_ff[`CSB_BC_MASK_RD]);
					end
				end
				default: state_ff <= csb_pkg::CSB_IDLE;
			endcase
		end
	end

	// bus error exception pulse, reads only
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_bus_err_exc <= 1'b0;
		end else begin
			o_bus_err_exc <= proc_en && state_ff == csb_pkg::CSB_RD
				&& i_bus_fault_in;
		end
	end

	// synced inputs get two flops, direct ones one: one cycle apart
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sync1_ff      <= 3'h7;
			sync2_ff      <= 3'h7;
			direct_ff     <= 3'h7;
			o_irq_pending <= 6'h00;
		end else begin
			sync1_ff  <= i_synced_irq_n;
			sync2_ff  <= sync1_ff;
			direct_ff <= i_direct_irq_n;
			o_irq_pending <= {~direct_ff, ~sync2_ff};
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	chk_lane_mask_rd: assert property (
		state_ff == csb_pkg::CSB_RD && $past(busctl_ff[0])
		&& $past(state_ff) == csb_pkg::CSB_IDLE
		|-> o_half_port_lane_strobe_n == 2'h3)
		else $error("lane strobes active on masked read");
	chk_last_release: assert property (
		$rose(o_rd_n) || $rose(o_wr_n) |-> o_last_n)
		else $error("final datum not released with strobe");
	chk_tc_pulse_len: assert property (
		$fell(o_timer_terminal_n) && !busctl_ff[1] && cmp_ff > 2
		&& !count_wr |-> !o_timer_terminal_n [*3] ##1 o_timer_terminal_n)
		else $error("terminal pulse not 1.5 processor cycles");
	chk_tc_hold: assert property (
		busctl_ff[1] && !o_timer_terminal_n && !count_wr
		&& !i_reg_wr |=> !o_timer_terminal_n)
		else $error("held terminal released without rewrite");
	chk_fault_ends: assert property (
		proc_en && state_ff != csb_pkg::CSB_IDLE && i_bus_fault_in
		|=> state_ff == csb_pkg::CSB_IDLE && o_rd_n && o_wr_n)
		else $error("bus fault did not end transfer");
	chk_berr_read: assert property (
		o_bus_err_exc |-> $past(state_ff) == csb_pkg::CSB_RD
		&& $past(i_bus_fault_in))
		else $error("bus error exception without read fault");
	chk_direct_lat: assert property (
		$past(!i_rst,2) |-> o_irq_pending[5:3] == ~$past(i_direct_irq_n,2))
		else $error("direct interrupt latency wrong");
	chk_synced_lat: assert property (
		$past(!i_rst,3) |-> o_irq_pending[2:0] == ~$past(i_synced_irq_n,3))
		else $error("synced interrupt latency wrong");
	chk_float_all: assert property (
		i_float_all_outputs |=> !o_lane_oe && !o_fixed_oe && !o_ctl_oe)
		else $error("outputs driven while float requested");
	chk_strap_stable: assert property (
		!$past(i_rst) |-> $stable(o_strap))
		else $error("strap changed after reset release");
	chk_lane_input: assert property (
		@(posedge i_clk_sys) disable iff (1'b0)
		i_rst |=> !o_lane_oe)
		else $error("lane pins driven during reset");
	chk_system_clock_out_div: assert property (
		!$past(i_rst) |-> o_system_clock_out != $past(o_system_clock_out))
		else $error("processor clock not half rate");

	cov_read_fault: cover property (
		state_ff == csb_pkg::CSB_RD && proc_en && i_bus_fault_in);
	cov_multi_datum: cover property (
		$fell(o_last_n) && !o_rd_n);
	cov_tc_hold: cover property (
		busctl_ff[1] && $fell(o_timer_terminal_n));
	cov_grant: cover property ($rose(o_bus_grant_out));
endmodule : csb_sideband

// [tb/csb_mem_model.sv]
`timescale 1ns/10ps
module csb_mem_model (
	// clock, reset and strobes from the core
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic       i_rd_n,
	input  wire logic       i_wr_n,
	input  wire logic       i_system_clock_out,
	// controls and answers
	input  wire logic [3:0] i_wait,
	input  wire logic       i_fault,
	output logic            o_read_data_strobe_n_n,
	output logic            o_ack_n,
	output logic            o_fault
);
	logic [3:0] cnt_ff;
	logic       go_ff;
	logic       act;

	assign act = !(i_rd_n && i_wr_n);
	// answer moves on the half the core does not sample, held over the next
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !act) begin
			cnt_ff <= 4'h0;
			go_ff  <= 1'b0;
		end else if (!i_system_clock_out) begin
			if (go_ff) begin
				go_ff  <= 1'b0;
				cnt_ff <= 4'h0;
			end
		end else if (cnt_ff >= i_wait)
			go_ff <= 1'b1;
		else
			cnt_ff <= cnt_ff + 4'h1;
	end
	// a fault takes the place of the datum answer
	assign o_read_data_strobe_n_n = !(go_ff && !i_rd_n && !i_fault);
	assign o_ack_n   = !(go_ff && !i_wr_n && !i_fault);
	assign o_fault   = go_ff && i_fault;
endmodule : csb_mem_model

// [tb/tb_csb_sideband.sv]
`timescale 1ns/10ps
`include "csb_defs.svh"
module tb_csb_sideband;
	logic                clk, rst, wr, rd, xv, fidle, freq, breq, flo;
	logic [7:0]          ad;
	logic [31:0]         wd, rdat, pa;
	logic [1:0]          lno, lnt;
	logic [2:0]          sirq, dirq;
	logic [3:0]          wt;
	logic [5:0]          pend;
	csb_pkg::csb_xfer_t  xf;
	csb_pkg::csb_strap_t strap;
	csb_pkg::csb_cache_t cch;
	logic                busy, exc, rdn, wrn, coe, lastn, loe;
	logic                tcn, sck, gnt, foe, rdc, ackn, mflt;
	int                  miscompares = 0;
	int                  num_checks = 0;

	csb_sideband u_dut (
		.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(ad), .i_reg_wdata(wd),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
		.i_xfer_valid(xv), .i_xfer(xf), .o_xfer_busy(busy),
		.o_bus_err_exc(exc), .o_paddr(pa),
		.i_read_data_strobe_n(rdc), .i_ack_n(ackn),
		.i_bus_fault_in(mflt | fidle), .i_bus_req(breq),
		.i_float_all_outputs(flo), .o_rd_n(rdn), .o_wr_n(wrn),
		.o_ctl_oe(coe), .o_last_n(lastn),
		.o_half_port_lane_strobe_n(lno), .o_lane_oe(loe),
		.i_half_port_lane_strobe_n(loe ? lno : lnt),
		.o_timer_terminal_n(tcn), .o_system_clock_out(sck),
		.o_bus_grant_out(gnt), .o_fixed_oe(foe),
		.i_synced_irq_n(sirq), .i_direct_irq_n(dirq),
		.o_irq_pending(pend), .o_strap(strap), .o_cache_cfg(cch));
	csb_mem_model u_mem (
		.i_clk_sys(clk), .i_rst(rst), .i_rd_n(rdn), .i_wr_n(wrn),
		.i_system_clock_out(sck), .i_wait(wt), .i_fault(freq),
		.o_read_data_strobe_n_n(rdc), .o_ack_n(ackn), .o_fault(mflt));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic results;
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic hang;
		miscompares++;
		results();
	endtask : hang
	// sample a little after the edge so its updates have landed
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : tk
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdat;
	endtask : reg_rd
	// lm bit k holds the final-datum level seen with datum k
	task automatic xfer(input logic r, input logic [31:0] va,
		input logic [2:0] nb, output logic [1:0] ln, output int nd,
		output logic [7:0] lm, output logic ex);
		int i;
		@(posedge clk);
		xf <= {r, !r, va, nb};
		xv <= 1'b1;
		for (i = 0; i < 10 && busy !== 1'b1; i++)
			tk(1);
		if (i == 10) hang();
		ln = lno;
		nd = 0;
		lm = 8'h00;
		ex = 1'b0;
		for (i = 0; i < 80 && busy === 1'b1; i++) begin
			if (sck === 1'b0 && (r ? rdc : ackn) === 1'b0) begin
				lm[nd] = lastn;
				nd++;
			end
			ex |= exc;
			@(posedge clk);
			xv <= 1'b0;
			#1;
		end
		if (i == 80) hang();
		ex |= exc;
		tk(1);
		ex |= exc;
	endtask : xfer

	task automatic t_reset;
		tk(2);
		chk(loe, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		tk(1);
		chk(strap, 4'ha);
		chk(loe, 1'b1);
		@(posedge clk);
		dirq <= 3'b111;
		lnt <= 2'b01;
		tk(2);
		chk(strap, 4'ha);
	endtask : t_reset
	task automatic t_regs;
		logic [31:0] d;
		reg_rd(`CSB_REG_BUSCTL, d);
		chk(d, `CSB_BUSCTL_RST);
		reg_rd(`CSB_REG_PORTSZ, d);
		chk(d, `CSB_PORTSZ_RST);
		reg_rd(`CSB_REG_CACHE, d);
		chk(d, `CSB_CACHE_RST);
		reg_wr(`CSB_REG_CACHE, 32'h3);
		tk(1);
		chk(cch, 2'h3);
		reg_wr(8'h40, 32'hffff_ffff);
		reg_rd(8'h40, d);
		chk(d, 32'h0);
		reg_wr(`CSB_REG_COMPARE, 32'hffff_ffff);
		reg_rd(`CSB_REG_COMPARE, d);
		chk(d, 32'h00ff_ffff);
	endtask : t_regs
	task automatic t_lanes;
		logic [1:0] ln;
		int         nd;
		logic [7:0] lm;
		logic       ex;
		// region 0 half width, region 1 byte wide, region 2 full width
		reg_wr(`CSB_REG_PORTSZ, 32'h9);
		xfer(1'b1, 32'h0000_0000, 3'h4, ln, nd, lm, ex);
		chk(ln, 2'b00);
		chk(nd, 2);
		chk(lm[1:0], 2'b01);
		xfer(1'b1, 32'ha000_0001, 3'h1, ln, nd, lm, ex);
		chk(pa, 32'h0000_0001);
		chk(ex, 1'b0);
		chk(ln, 2'b01);
		xfer(1'b0, 32'h0000_0002, 3'h1, ln, nd, lm, ex);
		chk(ln, 2'b10);
		wt = 4'h3;
		xfer(1'b1, 32'h1000_0000, 3'h4, ln, nd, lm, ex);
		chk(nd, 4);
		chk(lm[3:0], 4'b0111);
		wt = 4'h0;
		xfer(1'b0, 32'h6000_0000, 3'h4, ln, nd, lm, ex);
		chk(pa, 32'h6000_0000);
		chk({nd[3:0], lm[0]}, 5'h2);
		chk(ln, 2'b11);
		reg_wr(`CSB_REG_BUSCTL, 32'h1);
		xfer(1'b1, 32'h0000_0000, 3'h4, ln, nd, lm, ex);
		chk(ln, 2'b11);
		xfer(1'b0, 32'h0000_0000, 3'h4, ln, nd, lm, ex);
		chk(ln, 2'b00);
		reg_wr(`CSB_REG_BUSCTL, 32'h0);
	endtask : t_lanes
	task automatic t_fault;
		logic [1:0] ln;
		int         nd;
		logic [7:0] lm;
		logic       ex;
		freq <= 1'b1;
		xfer(1'b1, 32'h2000_0000, 3'h4, ln, nd, lm, ex);
		chk(ex, 1'b1);
		xfer(1'b0, 32'h2000_0000, 3'h4, ln, nd, lm, ex);
		chk(ex, 1'b0);
		freq = 1'b0;
		// a fault with no transfer open must be ignored
		@(posedge clk);
		fidle <= 1'b1;
		ex = 1'b0;
		repeat (4) begin
			tk(1);
			ex |= exc | busy;
		end
		chk(ex, 1'b0);
		@(posedge clk);
		fidle <= 1'b0;
	endtask : t_fault
	task automatic t_timer;
		int i;
		int w;
		logic [31:0] d;
		reg_wr(`CSB_REG_COMPARE, 32'h5);
		reg_wr(`CSB_REG_COUNT, 32'h0);
		for (i = 0; i < 60 && tcn !== 1'b0; i++)
			tk(1);
		if (i == 60) hang();
		for (w = 0; w < 60 && tcn === 1'b0; w++)
			tk(1);
		chk(w, `CSB_TC_CLKS);
		reg_wr(`CSB_REG_BUSCTL, 32'h2);
		for (i = 0; i < 60 && tcn !== 1'b0; i++)
			tk(1);
		if (i == 60) hang();
		tk(20);
		chk(tcn, 1'b0);
		reg_wr(`CSB_REG_COUNT, 32'h0);
		tk(2);
		chk(tcn, 1'b1);
		reg_wr(`CSB_REG_COMPARE, 32'hff_ffff);
		reg_wr(`CSB_REG_BUSCTL, 32'h0);
		// terminal idle, no transfer, straps from the first reset
		reg_rd(`CSB_REG_STATUS, d);
		chk(d, 32'h0000_000a);
	endtask : t_timer
	task automatic t_irq;
		int i;
		int d;
		int s;
		d = 0;
		s = 0;
		// driven on the clock edge, as the direct inputs need
		@(posedge clk);
		dirq <= 3'b101;
		sirq <= 3'b101;
		for (i = 1; i <= 8; i++) begin
			tk(1);
			if (d == 0 && pend[4] === 1'b1) d = i;
			if (s == 0 && pend[1] === 1'b1) s = i;
		end
		chk(d, 2);
		chk(s - d, 1);
		@(posedge clk);
		dirq <= 3'b111;
		sirq <= 3'b111;
		tk(4);
		chk(pend, 6'h0);
	endtask : t_irq
	task automatic t_big;
		logic [1:0] ln;
		int         nd;
		logic [7:0] lm;
		logic       ex;
		// second reset straps high byte first order
		@(posedge clk);
		rst  <= 1'b1;
		sirq <= 3'b110;
		tk(3);
		chk(loe, 1'b0);
		@(posedge clk);
		rst  <= 1'b0;
		sirq <= 3'b111;
		tk(1);
		chk(strap, 4'h5);
		chk(cch, `CSB_CACHE_RST);
		reg_wr(`CSB_REG_PORTSZ, 32'h1);
		xfer(1'b1, 32'h0000_0001, 3'h1, ln, nd, lm, ex);
		chk(ln, 2'b10);
		xfer(1'b1, 32'h0000_0002, 3'h1, ln, nd, lm, ex);
		chk(ln, 2'b01);
	endtask : t_big
	task automatic t_grant;
		int i;
		@(posedge clk);
		breq <= 1'b1;
		for (i = 0; i < 10 && gnt !== 1'b1; i++)
			tk(1);
		if (i == 10) hang();
		tk(1);
		chk(coe, 1'b0);
		@(posedge clk);
		breq <= 1'b0;
		tk(4);
		chk({gnt, coe}, 2'b01);
	endtask : t_grant
	task automatic t_float;
		logic c;
		@(posedge clk);
		flo <= 1'b1;
		tk(2);
		chk({coe, loe, foe}, 3'b000);
		@(posedge clk);
		flo <= 1'b0;
		tk(2);
		chk({coe, loe, foe}, 3'b111);
		c = sck;
		tk(1);
		chk(sck, !c);
		tk(1);
		chk(sck, c);
	endtask : t_float

	initial begin
		rst   = 1'b1;
		wr    = 1'b0;
		rd    = 1'b0;
		xv    = 1'b0;
		fidle = 1'b0;
		freq  = 1'b0;
		breq  = 1'b0;
		flo   = 1'b0;
		ad    = 8'h00;
		wd    = 32'h0;
		xf    = '0;
		lnt   = 2'b10;
		sirq  = 3'b111;
		dirq  = 3'b110;
		wt    = 4'h0;
		t_reset();
		t_regs();
		t_lanes();
		t_fault();
		t_timer();
		t_irq();
		t_big();
		t_grant();
		t_float();
		results();
	end
endmodule : tb_csb_sideband
